// ==== dv/target_stream_port_pair_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module target_stream_port_pair_chk
	import stream_port_pkg::*;
(
	input wire logic              clk,
	input wire logic              reset_n,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic              pready,
	input wire logic [11:0]       paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              treq_valid,
	input wire logic              treq_ready,
	input wire logic [DATA_W-1:0] treq_data,
	input wire logic [KEEP_W-1:0] treq_keep,
	input wire logic              treq_last,
	input wire logic [USER_W-1:0] treq_user,
	input wire logic              tresp_valid,
	input wire logic              tresp_ready,
	input wire logic [DATA_W-1:0] tresp_data,
	input wire logic              link_resp_valid,
	input wire logic              link_resp_ready,
	input wire logic [DATA_W-1:0] link_resp_data
);
	logic [2:0] ctrl_reg;
	logic       first_reg;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	// mode is shadowed from bus writes; only valid while no beat is in flight
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_reg <= CTRL_RESET;
			first_reg <= 1'b1;
		end else begin
			if (psel && penable && pready && pwrite && paddr == CTRL_ADDR)
				ctrl_reg <= pwdata[2:0];
			if (treq_valid && treq_ready)
				first_reg <= treq_last;
		end
	end
	AST_HDR_KEEP: assert property (treq_valid && !ctrl_reg[0] |-> treq_keep == KEEP_ALL)
		else $error("request keep not full in header mode");
	AST_RAW_KEEP: assert property (treq_valid && ctrl_reg[0] && !treq_last |-> treq_keep == KEEP_ALL)
		else $error("request keep not full before last raw beat");
	AST_RAW_USER: assert property (treq_valid && ctrl_reg[0] |-> treq_user[31:2] == 30'h0 && !treq_user[0])
		else $error("reserved raw sideband bit set");
	AST_ID8_PAD: assert property (treq_valid && first_reg && ctrl_reg[1:0] == 2'h2 |->
		treq_user[31:24] == 8'h00 && treq_user[15:8] == 8'h00)
		else $error("short id not padded");
	AST_HDR_TAIL: assert property (treq_valid && !first_reg && !ctrl_reg[0] |-> treq_user == 32'h0)
		else $error("sideband not cleared after first beat");
	AST_REQ_HOLD: assert property (treq_valid && !treq_ready |=>
		treq_valid && $stable({treq_data, treq_keep, treq_last, treq_user}))
		else $error("request beat changed before acceptance");
	AST_RESP_HOLD: assert property (link_resp_valid && !link_resp_ready |=>
		link_resp_valid && $stable(link_resp_data))
		else $error("response beat changed before acceptance");
	AST_RESP_PASS: assert property (tresp_valid && tresp_ready |=>
		link_resp_valid && link_resp_data == $past(tresp_data))
		else $error("accepted response beat not forwarded");
endmodule
bind target_stream_port_pair target_stream_port_pair_chk i_chk (.*);
`default_nettype wire

// ==== dv/target_stream_port_pair_test.sv ====
`timescale 1ns/1ps
`default_nettype none
module target_stream_port_pair_test
	import stream_port_pkg::*;
;
	logic              clk, reset_n, psel, penable, pwrite, pready, pslverr, err, hold, stall, sending;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata, rdata, rnd, sr;
	logic              link_req_valid, link_req_ready, link_req_last, link_req_crit_flow;
	logic [DATA_W-1:0] link_req_data, treq_data, tresp_data, link_resp_data;
	logic [KEEP_W-1:0] link_req_keep, treq_keep, tresp_keep, link_resp_keep;
	logic [ID_W-1:0]   link_req_src_id, link_req_dst_id, link_resp_src_id, link_resp_dst_id;
	logic              treq_valid, treq_ready, treq_last, tresp_valid, tresp_ready, tresp_last, rfirst, qf;
	logic [USER_W-1:0] treq_user, tresp_user;
	logic              link_resp_valid, link_resp_ready, link_resp_last, link_resp_first, link_resp_crit_flow;
	logic [2:0]        mode;
	logic              raw_mode, crit_en, spoil;
	int                error_cnt, comparisons, npkt, n;
	logic [BEAT_W-1:0] exp_req[$];
	logic [127:0]      exp_resp[$];
	logic [2:0]        modes[4] = '{3'h0, 3'h2, 3'h1, 3'h5};
	assign raw_mode = mode[CTRL_RAW_BIT];
	assign crit_en = mode[CTRL_CRIT_BIT];
	target_stream_port_pair i_target_stream_port_pair (.*);
	user_resp_model i_user_resp_model (.*);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [31:0] req_user(input logic f, input logic [15:0] s, d, input logic c);
		logic [15:0] mk;
		mk = mode[CTRL_ID8_BIT] ? 16'h00FF : 16'hFFFF;
		if (!f)
			return 32'h0;
		return raw_mode ? {30'h0, c, 1'b0} : {s & mk, d & mk};
	endfunction
	function automatic logic [32:0] side(input logic f, input logic [31:0] ids, input logic c);
		return {(f && !raw_mode) ? ids : 32'h0, f && raw_mode && c};
	endfunction
	task automatic check(input logic [127:0] got, input logic [127:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic bail();
		error_cnt++;
		$display("FAIL t=%0t wait expired got=%h exp=%h", $time, 1'b0, 1'b1);
		tally_and_finish();
	endtask
	always @(posedge clk) begin
		sr <= lfsr(sr);
		stall <= hold | (sr[0] & sr[1]);
		link_resp_ready <= !(sr[4] & sr[5]);
	end
	always @(negedge clk) begin
		if (reset_n && treq_valid && treq_ready) begin
			check({treq_data, treq_keep, treq_last, (qf || !raw_mode) ? treq_user : 32'h0},
				exp_req.pop_front());
			qf = treq_last;
		end
		if (reset_n && tresp_valid && tresp_ready) begin
			exp_resp.push_back({tresp_data, tresp_keep, tresp_last, rfirst, side(rfirst, tresp_user, tresp_user[1] & crit_en)});
			rfirst = tresp_last;
		end
		if (reset_n && link_resp_valid && link_resp_ready)
			check({link_resp_data, link_resp_keep, link_resp_last, link_resp_first,
				side(link_resp_first, {link_resp_src_id, link_resp_dst_id}, link_resp_crit_flow)},
				exp_resp.pop_front());
	end
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		k = 0;
		do @(posedge clk); while (pready !== 1'b1 && ++k < 100);
		if (k >= 100)
			bail();
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e);
		apb(1'b0, a, 32'h0);
		check({err, rdata}, e);
	endtask
	task automatic send_beat(input logic f, input logic l);
		int k;
		rnd = lfsr(rnd);
		link_req_valid <= 1'b1;
		link_req_data <= {rnd, ~rnd};
		link_req_keep <= rnd[15:8] | 8'h80;
		link_req_last <= l;
		link_req_src_id <= rnd[31:16];
		link_req_dst_id <= rnd[23:8];
		link_req_crit_flow <= rnd[3];
		exp_req.push_back({rnd, ~rnd, (raw_mode && l) ? (rnd[15:8] | 8'h80) : KEEP_ALL, l,
			req_user(f, rnd[31:16], rnd[23:8], rnd[3])});
		k = 0;
		do @(negedge clk); while (link_req_ready !== 1'b1 && ++k < 500);
		if (k >= 500)
			bail();
		@(posedge clk);
	endtask
	task automatic send_pkt(input int len);
		sending = 1'b1;
		npkt++;
		for (int b = 0; b < len; b++)
			send_beat(b == 0, b == len - 1);
		sending = 1'b0;
	endtask
	task automatic drain();
		int q;
		link_req_valid <= 1'b0;
		q = 0;
		for (int k = 0; k < 3000 && q < 8; k++) begin
			@(negedge clk);
			q = (sending || exp_req.size() || exp_resp.size() || tresp_valid || link_resp_valid) ? 0 : q + 1;
		end
		if (q < 8)
			bail();
		@(posedge clk);
	endtask
	initial begin
		{psel, penable, pwrite, link_req_valid, link_req_last, link_req_crit_flow, hold, sending, spoil} = '0;
		{paddr, pwdata, link_req_data, link_req_keep, link_req_src_id, link_req_dst_id} = '0;
		{stall, link_resp_ready, reset_n} = 3'h0;
		{rfirst, qf} = 2'h3;
		rnd = 32'hC102;
		sr = 32'hC102;
		mode = 3'h0;
		repeat (16) @(posedge clk);
		reset_n <= 1'b1;
		rd(CTRL_ADDR, {30'h0, CTRL_RESET});
		rd(12'h010, {1'b1, 32'h0});
		foreach (modes[i]) begin
			mode = modes[i];
			apb(1'b1, CTRL_ADDR, {29'h0, mode});
			rd(CTRL_ADDR, {30'h0, mode});
			repeat (6) begin
				rnd = lfsr(rnd);
				send_pkt(rnd[1:0] + 1);
			end
			drain();
			rd(REQ_CNT_ADDR, {17'h0, npkt[15:0]});
			rd(RESP_CNT_ADDR, {17'h0, npkt[15:0]});
			rd(STATUS_ADDR, 33'h8);
			$display("test mode %h done", mode);
		end
		// raw format, flag disabled: user raises it anyway, must be masked and flagged
		spoil = 1'b1;
		mode = 3'h1;
		apb(1'b1, CTRL_ADDR, {29'h0, mode});
		send_pkt(2);
		drain();
		spoil = 1'b0;
		rd(STATUS_ADDR, 33'h18);
		apb(1'b1, STATUS_ADDR, 32'h10);
		rd(STATUS_ADDR, 33'h8);
		$display("test flag mask done");
		// receiver stalls: buffer must refuse without losing beats
		hold = 1'b1;
		repeat (4) @(posedge clk);
		fork
			send_pkt(5);
		join_none
		for (n = 0; n < 100 && link_req_ready !== 1'b0; n++)
			@(negedge clk);
		check(link_req_ready, 1'b0);
		apb(1'b0, STATUS_ADDR, 32'h0);
		check(rdata[ST_BUF_FULL], 1'b1);
		hold = 1'b0;
		wait fork;
		drain();
		rd(REQ_CNT_ADDR, {17'h0, npkt[15:0]});
		$display("test stall done");
		tally_and_finish();
	end
endmodule
`default_nettype wire

// ==== dv/user_resp_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module user_resp_model
	import stream_port_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset_n,
	input  wire logic              stall,
	input  wire logic              raw_mode,
	input  wire logic              crit_en,
	input  wire logic              spoil,
	input  wire logic              treq_valid,
	input  wire logic [DATA_W-1:0] treq_data,
	input  wire logic [KEEP_W-1:0] treq_keep,
	input  wire logic              treq_last,
	input  wire logic [USER_W-1:0] treq_user,
	input  wire logic              tresp_ready,
	output logic                   treq_ready,
	output logic                   tresp_valid,
	output logic      [DATA_W-1:0] tresp_data,
	output logic      [KEEP_W-1:0] tresp_keep,
	output logic                   tresp_last,
	output logic      [USER_W-1:0] tresp_user
);
	logic [BEAT_W-1:0] q[$];
	logic              first_reg;
	logic [USER_W-1:0] echo;
	always_comb begin
		if (!first_reg)
			echo = '0;
		else if (raw_mode)
			echo = {30'h0, (treq_user[CRIT_FLOW_BIT] & crit_en) | spoil, 1'b0};
		else
			echo = {treq_user[DST_ID_HI:DST_ID_LO], treq_user[SRC_ID_HI:SRC_ID_LO]};
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			q.delete();
			first_reg <= 1'b1;
			treq_ready <= 1'b0;
			tresp_valid <= 1'b0;
			tresp_data <= '0;
			tresp_keep <= KEEP_ALL;
			tresp_last <= 1'b0;
			tresp_user <= '0;
		end else begin
			treq_ready <= !stall;
			if (treq_valid && treq_ready) begin
				q.push_back({treq_data, treq_keep, treq_last, echo});
				first_reg <= treq_last;
			end
			if (!tresp_valid || tresp_ready) begin
				if (q.size() > 0) begin
					{tresp_data, tresp_keep, tresp_last, tresp_user} <= q.pop_front();
					tresp_valid <= 1'b1;
				end else begin
					// idle lines wander so a stale beat cannot pass
					tresp_valid <= 1'b0;
					tresp_data <= ~tresp_data;
					tresp_keep <= KEEP_ALL;
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== shared/stream_port_pkg.sv ====
package stream_port_pkg;
	localparam int          DATA_W        = 64;
	localparam int          KEEP_W        = 8;
	localparam int          USER_W        = 32;
	localparam int          RAW_USER_W    = 8;
	localparam logic [7:0]  KEEP_ALL      = 8'hFF;
	localparam int          SRC_ID_HI     = 31;
	localparam int          SRC_ID_LO     = 16;
	localparam int          DST_ID_HI     = 15;
	localparam int          DST_ID_LO     = 0;
	localparam int          CRIT_FLOW_BIT = 1;
	localparam int          ID_W          = 16;
	localparam int          ID8_W         = 8;
	localparam int          ID_COUNT      = 2;
	// request beat packing: data, keep, last, user
	localparam int          BEAT_W        = DATA_W + KEEP_W + 1 + USER_W;
	// apb register map
	localparam logic [11:0] CTRL_ADDR     = 12'h000;
	localparam logic [11:0] STATUS_ADDR   = 12'h004;
	localparam logic [11:0] REQ_CNT_ADDR  = 12'h008;
	localparam logic [11:0] RESP_CNT_ADDR = 12'h00C;
	localparam int          CTRL_RAW_BIT  = 0;
	localparam int          CTRL_ID8_BIT  = 1;
	localparam int          CTRL_CRIT_BIT = 2;
	localparam logic [2:0]  CTRL_RESET    = 3'h0;
	localparam int          ST_REQ_MID    = 0;
	localparam int          ST_RESP_MID   = 1;
	localparam int          ST_BUF_FULL   = 2;
	localparam int          ST_BUF_EMPTY  = 3;
	localparam int          ST_RESP_ERR   = 4;
	localparam int          CNT_W         = 16;
endpackage

// ==== src/beat_buffer.sv ====
`timescale 1ns/1ps
`default_nettype none
// two-entry skid buffer; output data is muxed from the two entries by the read pointer
module beat_buffer #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 2
) (
	input  wire logic             clk,
	input  wire logic             reset_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  full,
	output logic                  empty
);
	if (DEPTH != 2 || WIDTH < 1) begin : g_bad_params
		$error("beat_buffer serves only two entries");
	end

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic             wptr_reg;
	logic             rptr_reg;
	logic [1:0]       count_reg;
	logic [1:0]       count_next;
	logic             push;
	logic             pop;

	assign push = in_valid && in_ready;
	assign pop  = out_valid && out_ready;
	assign count_next = 2'(count_reg + {1'b0, push} - {1'b0, pop});
	assign out_valid = (count_reg != 2'd0);
	assign full  = (count_reg == 2'd2);
	assign empty = (count_reg == 2'd0);
	assign out_data = mem_reg[rptr_reg];

	always_ff @(posedge clk) begin
		if (push)
			mem_reg[wptr_reg] <= in_data;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wptr_reg  <= 1'b0;
			rptr_reg  <= 1'b0;
			count_reg <= 2'd0;
			in_ready  <= 1'b0;
		end else begin
			// ready is a flop so the link side never sees a combinational path
			in_ready <= (count_next != 2'd2);
			if (push)
				wptr_reg <= ~wptr_reg;
			if (pop)
				rptr_reg <= ~rptr_reg;
			count_reg <= count_next;
		end
	end
endmodule
`default_nettype wire

// ==== src/target_stream_port_pair.sv ====
// Design decisions made here: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - header-encoded format: outbound request keep is all ones every beat
// - raw format: outbound request keep all ones except on the final beat
// - keep bit 7 covers data 63:56, bit 0 covers data 7:0
// - header-encoded sideband: source id 31:16, destination id 15:0, first beat
// - with 8-bit ids the upper byte of each id slot is zero
// - sideband on beats after the first is meaningless and ignored
// - raw format request sideband is 8 bits, bit 1 is critical flow
// - last-beat marker on exactly the final beat of each packet
// - beat moves only when valid and ready are both high
// - 64-bit data bus carries header in leading beats, then payload
module target_stream_port_pair
	import stream_port_pkg::*;
(
	input  wire logic                clk,
	input  wire logic                reset_n,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [11:0]         paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	// requests arriving from the link side
	input  wire logic                link_req_valid,
	output logic                     link_req_ready,
	input  wire logic [DATA_W-1:0]   link_req_data,
	input  wire logic                link_req_last,
	input  wire logic [KEEP_W-1:0]   link_req_keep,
	input  wire logic [ID_W-1:0]     link_req_src_id,
	input  wire logic [ID_W-1:0]     link_req_dst_id,
	input  wire logic                link_req_crit_flow,
	// outbound request channel to user logic
	output logic                     treq_valid,
	input  wire logic                treq_ready,
	output logic      [DATA_W-1:0]   treq_data,
	output logic      [KEEP_W-1:0]   treq_keep,
	output logic                     treq_last,
	output logic      [USER_W-1:0]   treq_user,
	// inbound response channel from user logic
	input  wire logic                tresp_valid,
	output logic                     tresp_ready,
	input  wire logic [DATA_W-1:0]   tresp_data,
	input  wire logic [KEEP_W-1:0]   tresp_keep,
	input  wire logic                tresp_last,
	input  wire logic [USER_W-1:0]   tresp_user,
	// responses toward the link side
	output logic                     link_resp_valid,
	input  wire logic                link_resp_ready,
	output logic      [DATA_W-1:0]   link_resp_data,
	output logic      [KEEP_W-1:0]   link_resp_keep,
	output logic                     link_resp_last,
	output logic                     link_resp_first,
	output logic      [ID_W-1:0]     link_resp_src_id,
	output logic      [ID_W-1:0]     link_resp_dst_id,
	output logic                     link_resp_crit_flow
);
	logic [2:0]        ctrl_reg;
	logic              req_mid_reg;
	logic              resp_mid_reg;
	logic              resp_err_reg;
	logic [CNT_W-1:0]  req_cnt_reg;
	logic [CNT_W-1:0]  resp_cnt_reg;
	logic              raw_mode;
	logic              id8_mode;
	logic              crit_en;

	assign raw_mode = ctrl_reg[CTRL_RAW_BIT];
	assign id8_mode = ctrl_reg[CTRL_ID8_BIT];
	assign crit_en  = ctrl_reg[CTRL_CRIT_BIT];

	function automatic logic [ID_W-1:0] fit_id(input logic [ID_W-1:0] id, input logic narrow);
		fit_id = narrow ? {{(ID_W-ID8_W){1'b0}}, id[ID8_W-1:0]} : id;
	endfunction

	// counters wrap silently; software works on deltas
	function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] v);
		bump = CNT_W'(v + 1'b1);
	endfunction

	// lane mapping assumes one keep bit per data byte
	if (KEEP_W * 8 != DATA_W || USER_W < 2 * ID_W || RAW_USER_W > USER_W) begin : g_bad_widths
		$error("stream widths do not fit the lane mapping");
	end

	function automatic logic [KEEP_W-1:0] keep_for(input logic raw, input logic last,
	                                               input logic [KEEP_W-1:0] keep);
		keep_for = (raw && last) ? keep : KEEP_ALL;
	endfunction

	// ---------------- request path ----------------
	logic              req_first;
	logic [KEEP_W-1:0] req_keep_fmt;
	logic [USER_W-1:0] req_user_fmt;
	logic [BEAT_W-1:0] req_beat_in;
	logic [BEAT_W-1:0] req_beat_out;
	logic              buf_out_valid;
	logic              buf_out_ready;
	logic              buf_full;
	logic              buf_empty;

	assign req_first = !req_mid_reg;

	always_comb begin
		req_keep_fmt = keep_for(raw_mode, link_req_last, link_req_keep);
		req_user_fmt = '0;
		if (req_first) begin
			if (raw_mode) begin
				req_user_fmt[CRIT_FLOW_BIT] = link_req_crit_flow;
			end else begin
				req_user_fmt[SRC_ID_HI:SRC_ID_LO] = fit_id(link_req_src_id, id8_mode);
				req_user_fmt[DST_ID_HI:DST_ID_LO] = fit_id(link_req_dst_id, id8_mode);
			end
		end
	end

	// lanes kept in place, header beats lead
	assign req_beat_in = {link_req_data, req_keep_fmt, link_req_last, req_user_fmt};

	beat_buffer #(
		.WIDTH (BEAT_W),
		.DEPTH (2)
	) req_buf (
		.clk       (clk),
		.reset_n   (reset_n),
		.in_valid  (link_req_valid),
		.in_ready  (link_req_ready),
		.in_data   (req_beat_in),
		.out_valid (buf_out_valid),
		.out_ready (buf_out_ready),
		.out_data  (req_beat_out),
		.full      (buf_full),
		.empty     (buf_empty)
	);

	// output stage register so every port comes from a flop
	// hold until accepted
	assign buf_out_ready = !treq_valid || treq_ready;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			treq_valid <= 1'b0;
			treq_data  <= '0;
			treq_keep  <= KEEP_ALL;
			treq_last  <= 1'b0;
			treq_user  <= '0;
		end else if (buf_out_ready) begin
			treq_valid <= buf_out_valid;
			if (buf_out_valid) begin
				treq_data <= req_beat_out[BEAT_W-1 -: DATA_W];
				treq_keep <= req_beat_out[USER_W+1 +: KEEP_W];
				// last marker passes with its beat
				treq_last <= req_beat_out[USER_W];
				treq_user <= req_beat_out[USER_W-1:0];
			end
		end
	end

	// packet position on the link side, taken on accepted beats
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			req_mid_reg <= 1'b0;
		else if (link_req_valid && link_req_ready)
			req_mid_reg <= !link_req_last;
	end

	// ---------------- response path ----------------
	logic resp_take;
	logic resp_first;
	logic resp_bad;

	// accept only when the outgoing stage can move
	assign resp_take  = tresp_valid && tresp_ready;
	assign resp_first = !resp_mid_reg;
	// flag a user beat that breaks the keep or flag rules
	assign resp_bad = (tresp_keep != keep_for(raw_mode, tresp_last, tresp_keep))
	               || (raw_mode && resp_first && !crit_en && tresp_user[CRIT_FLOW_BIT]);

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			tresp_ready <= 1'b0;
		else
			tresp_ready <= !(link_resp_valid && !link_resp_ready) && !resp_take;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			link_resp_valid     <= 1'b0;
			link_resp_data      <= '0;
			link_resp_keep      <= KEEP_ALL;
			link_resp_last      <= 1'b0;
			link_resp_first     <= 1'b0;
			link_resp_src_id    <= '0;
			link_resp_dst_id    <= '0;
			link_resp_crit_flow <= 1'b0;
		end else if (resp_take) begin
			link_resp_valid <= 1'b1;
			link_resp_data  <= tresp_data;
			link_resp_keep  <= keep_for(raw_mode, tresp_last, tresp_keep);
			link_resp_last  <= tresp_last;
			link_resp_first <= resp_first;
			// sideband only sampled on first beat
			if (resp_first) begin
				if (raw_mode) begin
					link_resp_src_id    <= '0;
					link_resp_dst_id    <= '0;
					link_resp_crit_flow <= crit_en && tresp_user[CRIT_FLOW_BIT];
				end else begin
					link_resp_src_id    <= fit_id(tresp_user[SRC_ID_HI:SRC_ID_LO], id8_mode);
					link_resp_dst_id    <= fit_id(tresp_user[DST_ID_HI:DST_ID_LO], id8_mode);
					link_resp_crit_flow <= 1'b0;
				end
			end
		end else if (link_resp_ready) begin
			link_resp_valid <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			resp_mid_reg <= 1'b0;
		else if (resp_take)
			resp_mid_reg <= !tresp_last;
	end

	// ---------------- counters ----------------
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			req_cnt_reg <= '0;
		else if (treq_valid && treq_ready && treq_last)
			req_cnt_reg <= bump(req_cnt_reg);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			resp_cnt_reg <= '0;
		else if (resp_take && tresp_last)
			resp_cnt_reg <= bump(resp_cnt_reg);
	end

	// ---------------- apb slave ----------------
	logic        apb_access;
	logic        status_w1c;
	logic [31:0] status_word;

	// status bits placed by their package positions
	always_comb begin
		status_word               = '0;
		status_word[ST_REQ_MID]   = req_mid_reg;
		status_word[ST_RESP_MID]  = resp_mid_reg;
		status_word[ST_BUF_FULL]  = buf_full;
		status_word[ST_BUF_EMPTY] = buf_empty;
		status_word[ST_RESP_ERR]  = resp_err_reg;
	end

	// zero wait states: each access completes in its first access cycle
	assign apb_access = psel && penable;
	assign status_w1c = apb_access && pwrite && paddr == STATUS_ADDR && pwdata[ST_RESP_ERR];

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			ctrl_reg <= CTRL_RESET;
		else if (apb_access && pwrite && paddr == CTRL_ADDR)
			ctrl_reg <= pwdata[2:0];
	end

	// sticky error: a new offence wins over the clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			resp_err_reg <= 1'b0;
		else if (resp_take && resp_bad)
			resp_err_reg <= 1'b1;
		else if (status_w1c)
			resp_err_reg <= 1'b0;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			prdata  <= '0;
			if (psel && !penable) begin
				unique case (paddr)
					CTRL_ADDR:     prdata <= {29'h0, ctrl_reg};
					STATUS_ADDR:   prdata <= status_word;
					REQ_CNT_ADDR:  prdata <= {16'h0, req_cnt_reg};
					RESP_CNT_ADDR: prdata <= {16'h0, resp_cnt_reg};
					default:       pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule
`default_nettype wire
